// File: rtl/ctmw_defs.vh
/*
 * constants of the transceiver mode and wake control block: mode codes,
 * system mode codes, wake filter and enabling delay times and cycle counts.
 * assumes a 250 MHz internal clock.
 */
`ifndef CTMW_DEFS_VH
`define CTMW_DEFS_VH

// ****************************************
// transceiver mode codes (2-bit field)
// ****************************************
`define CTMW_MODE_OFF      2'h0
`define CTMW_MODE_WAKE     2'h1
`define CTMW_MODE_RXONLY   2'h2
`define CTMW_MODE_NORMAL   2'h3
`define CTMW_MODE_RESET    2'h0

// ****************************************
// system mode codes (3-bit input)
// ****************************************
`define CTMW_SYS_NORMAL    3'h0
`define CTMW_SYS_STOP      3'h1
`define CTMW_SYS_SLEEP     3'h2
`define CTMW_SYS_RESTART   3'h3
`define CTMW_SYS_FAILSAFE  3'h4

// ****************************************
// timing
// ****************************************
`define CTMW_CLK_MHZ       250
`define CTMW_WAKE_MIN_NS   500
`define CTMW_WAKE_MAX_NS   5000
`define CTMW_TXEN_NS       200
// least times round up, longest times round down
`define CTMW_WAKE_MIN_CYC  ((`CTMW_WAKE_MIN_NS * `CTMW_CLK_MHZ + 999) / 1000)
`define CTMW_WAKE_MAX_CYC  ((`CTMW_WAKE_MAX_NS * `CTMW_CLK_MHZ) / 1000)
`define CTMW_TXEN_CYC      ((`CTMW_TXEN_NS * `CTMW_CLK_MHZ + 999) / 1000)

`endif

// File: rtl/ctmw_phase_timer.v
/*
 * phase timer: counts cycles the bus level has stood unchanged and flags
 * whether the phase that just ended lay strictly between the two limits.
 * assumes the bus level input is already synchronous to ref_clk.
 */
`timescale 1ns/1ns
`default_nettype none

module ctmw_phase_timer #(
    parameter CNT_W   = 12,
    parameter MIN_CYC = 125,
    parameter MAX_CYC = 1250
) (
    input  wire             ref_clk,
    input  wire             reset_n,
    input  wire             clear,
    input  wire             level,
    output reg              edge_seen_r,
    output reg              phase_ok_r,
    output reg              too_long_r
);

    reg  [CNT_W-1:0]        cnt_r;
    reg                     level_r;
    wire                    change;
    wire                    in_window;

    assign change    = (level != level_r);
    assign in_window = (cnt_r > MIN_CYC[CNT_W-1:0]) && (cnt_r < MAX_CYC[CNT_W-1:0]);

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r       <= {CNT_W{1'b0}};
            // idle bus is recessive, so no false edge right after reset
            level_r     <= 1'b0;
            edge_seen_r <= 1'b0;
            phase_ok_r  <= 1'b0;
            too_long_r  <= 1'b0;
        end else begin
            level_r     <= level;
            edge_seen_r <= change & ~clear;
            phase_ok_r  <= change & in_window;
            // saturate so a stuck bus never wraps back into the window
            if (clear || change) begin
                cnt_r <= {{(CNT_W-1){1'b0}}, 1'b1};
            end else if (cnt_r != {CNT_W{1'b1}}) begin
                cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
            end
            too_long_r  <= ~clear && (cnt_r >= MAX_CYC[CNT_W-1:0]);
        end
    end

endmodule // ctmw_phase_timer

`default_nettype wire

// File: rtl/ctmw_can_mode_wake.v
/*
 * transceiver mode control and bus wake detection of a high-speed CAN
 * transceiver: mode selection gated by system mode, transmit enabling
 * delay, receive output and wake pattern recognition.
 * assumes the mode write strobe, system mode, tx_input and bus level are
 * synchronous to ref_clk; the analog driver and receiver stand outside.
 */
// Function
// - after power-up the transceiver is off, driver off, bus pins high impedance.
// - off mode may be selected in every system mode.
// - in off mode bus wake activity is ignored, no wake indication.
// - transceiver mode is chosen by a mode field written over SPI.
// - normal mode is enabled by SPI write in normal system mode.
// - normal mode is allowed only in normal or stop system mode.
// - in normal mode the driver follows tx_input: low dominant, high recessive.
// - dominant already present when delay ends never reaches the bus.
// - with an active receiver the receive output shows the bus state.
// - receive-only mode disables the driver, receiver keeps working.
// - receive-only mode selectable only in normal or stop system mode.
// - wake-capable mode allowed in stop, sleep, restart, normal; bus monitored.
// - entering fail-safe switches the transceiver to wake-capable by itself.
// - after a wake the receive output stays low until another mode is written.
// - after a wake an SPI write to normal mode is accepted.
// - wake pattern is dominant, recessive, dominant, each between the two limits.
// - entering stop or fail-safe re-arms wake detection automatically.
// - wake in sleep requests restart system mode and drives receive output low.
`timescale 1ns/1ns
`default_nettype none
`include "ctmw_defs.vh"

module ctmw_can_mode_wake #(
    parameter CNT_W    = 12,
    parameter MIN_CYC  = `CTMW_WAKE_MIN_CYC,
    parameter MAX_CYC  = `CTMW_WAKE_MAX_CYC,
    parameter TXEN_CYC = `CTMW_TXEN_CYC
) (
    input  wire             ref_clk,
    input  wire             reset_n,
    input  wire [2:0]       sys_mode,
    input  wire             mode_wr,
    input  wire [1:0]       mode_wdata,
    output wire [1:0]       mode_field,
    input  wire             tx_input,
    input  wire             bus_dominant,
    output reg              rx_output_r,
    output reg              drv_dominant_r,
    output reg              drv_enable_r,
    output reg              bias_enable_r,
    output reg              wake_flag_r,
    output reg              restart_req_r,
    output reg              tx_ready_r
);

    // ****************************************
    // mode register
    // ****************************************
    reg  [1:0]              mode_r;
    reg  [1:0]              mode_nxt;
    reg  [2:0]              sys_prev_r;
    reg                     mode_allowed;
    wire                    enter_failsafe;
    wire                    enter_stop;

    assign mode_field     = mode_r;
    assign enter_failsafe = (sys_mode == `CTMW_SYS_FAILSAFE) && (sys_prev_r != `CTMW_SYS_FAILSAFE);
    assign enter_stop     = (sys_mode == `CTMW_SYS_STOP) && (sys_prev_r != `CTMW_SYS_STOP);

    always @* begin
        case (mode_wdata)
            `CTMW_MODE_OFF: begin
                mode_allowed = 1'b1;
            end
            `CTMW_MODE_NORMAL, `CTMW_MODE_RXONLY: begin
                mode_allowed = (sys_mode == `CTMW_SYS_NORMAL) ||
                               (sys_mode == `CTMW_SYS_STOP);
            end
            `CTMW_MODE_WAKE: begin
                mode_allowed = (sys_mode == `CTMW_SYS_NORMAL) ||
                               (sys_mode == `CTMW_SYS_STOP) ||
                               (sys_mode == `CTMW_SYS_SLEEP) ||
                               (sys_mode == `CTMW_SYS_RESTART);
            end
            default: begin
                mode_allowed = 1'b0;
            end
        endcase
    end

    always @* begin
        mode_nxt = mode_r;
        if (enter_failsafe) begin
            mode_nxt = `CTMW_MODE_WAKE;
        end else if (mode_wr && mode_allowed) begin
            mode_nxt = mode_wdata;
        end
    end

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_r     <= `CTMW_MODE_RESET;
            sys_prev_r <= `CTMW_SYS_NORMAL;
        end else begin
            mode_r     <= mode_nxt;
            sys_prev_r <= sys_mode;
        end
    end

    // ****************************************
    // transmit enabling delay
    // ****************************************
    // counted from the cycle normal mode is entered; tx only goes live on
    // the first cycle tx_input is high after the delay, so a held low never leaks out
    reg  [CNT_W-1:0]        txen_cnt_r;
    reg                     tx_live_r;
    wire                    in_normal;

    assign in_normal = (mode_r == `CTMW_MODE_NORMAL);

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            txen_cnt_r <= {CNT_W{1'b0}};
            tx_live_r  <= 1'b0;
            tx_ready_r <= 1'b0;
        end else begin
            if (!in_normal) begin
                txen_cnt_r <= {CNT_W{1'b0}};
                tx_ready_r <= 1'b0;
                tx_live_r  <= 1'b0;
            end else if (!tx_ready_r) begin
                if (txen_cnt_r >= TXEN_CYC[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1}) begin
                    tx_ready_r <= 1'b1;
                end
                txen_cnt_r <= txen_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
            end else if (!tx_live_r && tx_input) begin
                tx_live_r <= 1'b1;
            end
        end
    end

    // ****************************************
    // wake pattern detector
    // ****************************************
    localparam ST_IDLE  = 3'h0;
    localparam ST_DOM1  = 3'h1;
    localparam ST_REC   = 3'h2;
    localparam ST_DOM2  = 3'h3;
    localparam ST_WOKEN = 3'h4;

    reg  [2:0]              wst_r;
    reg  [2:0]              wst_nxt;
    wire                    edge_seen;
    wire                    phase_ok;
    wire                    too_long;
    wire                    monitor;
    wire                    rearm;
    wire                    wake_hit;

    assign monitor  = (mode_r == `CTMW_MODE_WAKE);
    assign rearm    = !monitor || enter_stop || enter_failsafe;

    ctmw_phase_timer #(
        .CNT_W   (CNT_W),
        .MIN_CYC (MIN_CYC),
        .MAX_CYC (MAX_CYC)
    ) u_phase (
        .ref_clk     (ref_clk),
        .reset_n     (reset_n),
        .clear       (rearm),
        .level       (bus_dominant),
        .edge_seen_r (edge_seen),
        .phase_ok_r  (phase_ok),
        .too_long_r  (too_long)
    );

    // gated by the mode itself: a pattern that completes in the very cycle
    // the mode leaves wake-capable must not raise a late indication
    assign wake_hit = monitor && (wst_r == ST_DOM2) && edge_seen && phase_ok;

    always @* begin
        wst_nxt = wst_r;
        case (wst_r)
            ST_IDLE: begin
                if (edge_seen && !bus_dominant) begin
                    wst_nxt = wst_r;
                end else if (edge_seen) begin
                    wst_nxt = ST_DOM1;
                end
            end
            ST_DOM1, ST_REC, ST_DOM2: begin
                // each phase must end strictly between the two limits
                if (too_long) begin
                    wst_nxt = bus_dominant ? ST_IDLE : ST_IDLE;
                end else if (edge_seen && !phase_ok) begin
                    wst_nxt = bus_dominant ? ST_DOM1 : ST_IDLE;
                end else if (edge_seen) begin
                    wst_nxt = (wst_r == ST_DOM1) ? ST_REC :
                              (wst_r == ST_REC)  ? ST_DOM2 : ST_WOKEN;
                end
            end
            ST_WOKEN: begin
                wst_nxt = ST_WOKEN;
            end
            default: begin
                wst_nxt = ST_IDLE;
            end
        endcase
        if (rearm) begin
            wst_nxt = ST_IDLE;
        end
    end

    // ****************************************
    // wake indication
    // ****************************************
    reg                     wake_flag_nxt;
    reg                     restart_req_nxt;

    // the flag is sticky while the mode stays wake-capable; leaving the mode
    // is the only clear, and no hit can fall in that cycle since wake_hit needs the mode
    always @* begin
        wake_flag_nxt   = wake_flag_r;
        restart_req_nxt = wake_hit && (sys_mode == `CTMW_SYS_SLEEP);
        if (wake_hit) begin
            wake_flag_nxt = 1'b1;
        end else if (!monitor) begin
            wake_flag_nxt = 1'b0;
        end
    end

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wst_r         <= ST_IDLE;
            wake_flag_r   <= 1'b0;
            restart_req_r <= 1'b0;
        end else begin
            wst_r         <= wst_nxt;
            restart_req_r <= restart_req_nxt;
            wake_flag_r   <= wake_flag_nxt;
        end
    end

    // ****************************************
    // driver and receive output
    // ****************************************
    reg                     rx_active;
    reg                     rx_output_nxt;
    reg                     drv_enable_nxt;
    reg                     drv_dominant_nxt;
    reg                     bias_enable_nxt;

    // the full receiver and bias only run in normal and receive-only; in
    // wake-capable mode the receive output carries the wake indication
    always @* begin
        rx_active        = in_normal || (mode_r == `CTMW_MODE_RXONLY);
        drv_enable_nxt   = in_normal && tx_live_r;
        drv_dominant_nxt = in_normal && tx_live_r && !tx_input;
        bias_enable_nxt  = rx_active;
        if (monitor) begin
            rx_output_nxt = !(wake_flag_r || wake_hit);
        end else if (rx_active) begin
            rx_output_nxt = !bus_dominant;
        end else begin
            rx_output_nxt = 1'b1;
        end
    end

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            drv_enable_r   <= 1'b0;
            drv_dominant_r <= 1'b0;
            bias_enable_r  <= 1'b0;
            rx_output_r    <= 1'b1;
        end else begin
            drv_enable_r   <= drv_enable_nxt;
            drv_dominant_r <= drv_dominant_nxt;
            bias_enable_r  <= bias_enable_nxt;
            rx_output_r    <= rx_output_nxt;
        end
    end

endmodule // ctmw_can_mode_wake

`default_nettype wire

// File: test/ctmw_bus_model.sv
/*
 * bus partner: the wired bus seen by the receiver, dominant when our driver
 * or another node pulls it. assumes other_dom comes from the bench.
 */
`timescale 1ns/1ns
`default_nettype none

module ctmw_bus_model (
    input  wire logic ref_clk,
    input  wire logic drv_enable_r,
    input  wire logic drv_dominant_r,
    input  wire logic other_dom,
    output var  logic bus_dominant
);
    // ****************************************
    // wired bus, one cycle of loop delay
    // ****************************************
    // a disabled driver can never pull the bus, as a real stage in high impedance
    initial bus_dominant = 1'b0;
    always @(posedge ref_clk) begin
        bus_dominant <= (drv_enable_r & drv_dominant_r) | other_dom;
    end
endmodule // ctmw_bus_model

`default_nettype wire

// File: test/ctmw_can_mode_wake_assertions.sv
/*
 * checker of the mode and wake block, seeing only its ports.
 * assumes one clock ref_clk and async active low reset_n.
 */
`timescale 1ns/1ns
`default_nettype none
`include "ctmw_defs.vh"

module ctmw_can_mode_wake_assertions #(
    parameter TXEN_CYC = 50
) (
    input wire logic       ref_clk,
    input wire logic       reset_n,
    input wire logic [2:0] sys_mode,
    input wire logic       mode_wr,
    input wire logic [1:0] mode_wdata,
    input wire logic [1:0] mode_field,
    input wire logic       tx_input,
    input wire logic       bus_dominant,
    input wire logic       rx_output_r,
    input wire logic       drv_dominant_r,
    input wire logic       drv_enable_r,
    input wire logic       bias_enable_r,
    input wire logic       wake_flag_r,
    input wire logic       restart_req_r,
    input wire logic       tx_ready_r
);
    // ****************************************
    // helper: cycles spent in normal mode
    // ****************************************
    logic [15:0] norm_cnt_r;
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) norm_cnt_r <= 16'h0;
        else norm_cnt_r <= (mode_field == `CTMW_MODE_NORMAL) ? norm_cnt_r + 16'h1 : 16'h0;
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_off2;
        (mode_field == `CTMW_MODE_OFF) [*2];
    endsequence
    sequence s_woken;
        wake_flag_r && mode_field == `CTMW_MODE_WAKE;
    endsequence

    // ****************************************
    // assertions
    // ****************************************
    AST_OFF_QUIET: assert property (s_off2 |-> !drv_enable_r && !bias_enable_r)
        else $error("driver or bias active in off mode");
    AST_OFF_NO_WAKE: assert property (mode_field == `CTMW_MODE_OFF &&
        $past(mode_field) == `CTMW_MODE_OFF |-> !wake_flag_r && rx_output_r)
        else $error("wake seen in off mode");
    AST_ACCEPT: assert property (mode_wr && sys_mode == $past(sys_mode) &&
        (mode_wdata == `CTMW_MODE_OFF || sys_mode <= 3'h1 ||
        (mode_wdata == `CTMW_MODE_WAKE && sys_mode <= 3'h3)) |=> mode_field == $past(mode_wdata))
        else $error("allowed mode write not taken");
    AST_REFUSE: assert property (mode_wr && mode_wdata[1] &&
        (sys_mode == `CTMW_SYS_SLEEP || sys_mode == `CTMW_SYS_RESTART) |=> $stable(mode_field))
        else $error("disallowed mode write taken");
    AST_FAILSAFE: assert property (sys_mode == `CTMW_SYS_FAILSAFE &&
        $past(sys_mode) != `CTMW_SYS_FAILSAFE |=> mode_field == `CTMW_MODE_WAKE)
        else $error("fail-safe entry did not select wake mode");
    AST_TXEN: assert property (mode_field == `CTMW_MODE_NORMAL &&
        (tx_ready_r || drv_enable_r) |-> norm_cnt_r >= TXEN_CYC)
        else $error("transmit enabled before delay");
    AST_TX_FOLLOW: assert property ($past(mode_field) == `CTMW_MODE_NORMAL && drv_enable_r &&
        $past(drv_enable_r) |-> drv_dominant_r == !$past(tx_input))
        else $error("driver does not follow transmit input");
    AST_RX_FOLLOW: assert property ($past(mode_field) == `CTMW_MODE_NORMAL ||
        $past(mode_field) == `CTMW_MODE_RXONLY |-> rx_output_r == !$past(bus_dominant))
        else $error("receive output does not follow bus");
    AST_RXONLY: assert property ($past(mode_field) == `CTMW_MODE_RXONLY |->
        !drv_enable_r && bias_enable_r)
        else $error("receive-only mode drives bus");
    AST_WAKE_HOLD: assert property (s_woken ##1 mode_field == `CTMW_MODE_WAKE |->
        !rx_output_r)
        else $error("receive output not low after wake");
    AST_RESTART: assert property (restart_req_r |-> ##[0:3] wake_flag_r)
        else $error("restart request without wake");
endmodule // ctmw_can_mode_wake_assertions

bind ctmw_can_mode_wake ctmw_can_mode_wake_assertions #(.TXEN_CYC(TXEN_CYC)) u_chk (
    .ref_clk(ref_clk), .reset_n(reset_n), .sys_mode(sys_mode), .mode_wr(mode_wr),
    .mode_wdata(mode_wdata), .mode_field(mode_field), .tx_input(tx_input),
    .bus_dominant(bus_dominant), .rx_output_r(rx_output_r), .drv_dominant_r(drv_dominant_r),
    .drv_enable_r(drv_enable_r), .bias_enable_r(bias_enable_r), .wake_flag_r(wake_flag_r),
    .restart_req_r(restart_req_r), .tx_ready_r(tx_ready_r));

`default_nettype wire

// File: test/ctmw_can_mode_wake_bench.sv
/*
 * self-checking bench of the mode and wake block with a bus partner.
 * assumes short sim counts: 5/40 phase limits, 4 cycle enabling delay.
 */
`timescale 1ns/1ns
`default_nettype none
`include "ctmw_defs.vh"
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
    $display("CHECK FAILED %s exp=%h got=%h", nm, exp, got); end end

module ctmw_can_mode_wake_bench;
    logic       ref_clk, reset_n, mode_wr, tx_input, other_dom, bus_dominant, saw_rst;
    logic [2:0] sys_mode;
    logic [1:0] mode_wdata, mode_field;
    logic       rx_output_r, drv_dominant_r, drv_enable_r, bias_enable_r;
    logic       wake_flag_r, restart_req_r, tx_ready_r;
    int         err_count, n_compared;

    ctmw_can_mode_wake #(.CNT_W(12), .MIN_CYC(5), .MAX_CYC(40), .TXEN_CYC(4)) i_dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .sys_mode(sys_mode), .mode_wr(mode_wr),
        .mode_wdata(mode_wdata), .mode_field(mode_field), .tx_input(tx_input),
        .bus_dominant(bus_dominant), .rx_output_r(rx_output_r),
        .drv_dominant_r(drv_dominant_r), .drv_enable_r(drv_enable_r),
        .bias_enable_r(bias_enable_r), .wake_flag_r(wake_flag_r),
        .restart_req_r(restart_req_r), .tx_ready_r(tx_ready_r));
    ctmw_bus_model u_bus (.ref_clk(ref_clk), .drv_enable_r(drv_enable_r),
        .drv_dominant_r(drv_dominant_r), .other_dom(other_dom), .bus_dominant(bus_dominant));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (restart_req_r === 1'b1) saw_rst <= 1'b1;

    // ****************************************
    // helpers
    // ****************************************
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic set_mode(input logic [1:0] code);
        mode_wr = 1'b1;
        mode_wdata = code;
        cyc(1);
        mode_wr = 1'b0;
        cyc(1);
    endtask
    // another node sends dominant, recessive, dominant of len cycles each
    task automatic wake_pat(input int len);
        other_dom = 1'b1;
        cyc(len);
        other_dom = 1'b0;
        cyc(len);
        other_dom = 1'b1;
        cyc(len);
        other_dom = 1'b0;
    endtask
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wait_wake;
        for (int i = 0; i < 40 && wake_flag_r !== 1'b1; i++) cyc(1);
        if (wake_flag_r !== 1'b1) begin
            err_count++;
            $display("CHECK FAILED wake_flag exp=1 got=%b", wake_flag_r);
            stop_test();
        end
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_modes;
        sys_mode = `CTMW_SYS_SLEEP;
        set_mode(`CTMW_MODE_NORMAL);
        `CHK("mode_sleep_normal", `CTMW_MODE_OFF, mode_field)
        set_mode(`CTMW_MODE_RXONLY);
        `CHK("mode_sleep_rxonly", `CTMW_MODE_OFF, mode_field)
        set_mode(`CTMW_MODE_WAKE);
        `CHK("mode_sleep_wake", `CTMW_MODE_WAKE, mode_field)
        set_mode(`CTMW_MODE_OFF);
        `CHK("mode_sleep_off", `CTMW_MODE_OFF, mode_field)
        sys_mode = `CTMW_SYS_NORMAL;
        set_mode(`CTMW_MODE_RXONLY);
        `CHK("drv_rxonly", 1'b0, drv_enable_r)
        `CHK("bias_rxonly", 1'b1, bias_enable_r)
        other_dom = 1'b1;
        cyc(3);
        `CHK("rx_rxonly", 1'b0, rx_output_r)
        other_dom = 1'b0;
        $display("test modes done");
    endtask

    task automatic t_tx;
        tx_input = 1'b0; // low across the delay on purpose
        set_mode(`CTMW_MODE_NORMAL);
        cyc(10);
        `CHK("dom_held_low", 1'b0, drv_dominant_r)
        tx_input = 1'b1;
        cyc(3);
        tx_input = 1'b0;
        cyc(2);
        `CHK("dom_tx_low", 1'b1, drv_dominant_r)
        cyc(2);
        `CHK("rx_tx_low", 1'b0, rx_output_r)
        tx_input = 1'b1;
        cyc(4);
        `CHK("dom_tx_high", 1'b0, drv_dominant_r)
        `CHK("rx_tx_high", 1'b1, rx_output_r)
        $display("test transmit done");
    endtask

    task automatic t_wake;
        set_mode(`CTMW_MODE_OFF);
        wake_pat(15);
        cyc(6);
        `CHK("wake_in_off", 1'b0, wake_flag_r)
        sys_mode = `CTMW_SYS_SLEEP;
        set_mode(`CTMW_MODE_WAKE);
        wake_pat(3);
        cyc(50);
        `CHK("wake_short", 1'b0, wake_flag_r)
        wake_pat(15);
        wait_wake();
        cyc(2);
        `CHK("rx_woken", 1'b0, rx_output_r)
        `CHK("mode_woken", `CTMW_MODE_WAKE, mode_field)
        `CHK("restart_seen", 1'b1, saw_rst)
        sys_mode = `CTMW_SYS_NORMAL;
        set_mode(`CTMW_MODE_NORMAL);
        `CHK("mode_after_wake", `CTMW_MODE_NORMAL, mode_field)
        set_mode(`CTMW_MODE_WAKE); // toggle away and back
        `CHK("wake_rearmed", 1'b0, wake_flag_r)
        set_mode(`CTMW_MODE_OFF);
        sys_mode = `CTMW_SYS_FAILSAFE;
        cyc(3);
        `CHK("mode_failsafe", `CTMW_MODE_WAKE, mode_field)
        wake_pat(15);
        wait_wake();
        $display("test wake done");
    endtask

    initial begin
        reset_n = 1'b0;
        sys_mode = `CTMW_SYS_NORMAL;
        mode_wr = 1'b0;
        mode_wdata = 2'h0;
        tx_input = 1'b1;
        other_dom = 1'b0;
        saw_rst = 1'b0;
        err_count = 0;
        n_compared = 0;
        cyc(5);
        reset_n = 1'b1;
        cyc(1);
        `CHK("mode_reset", `CTMW_MODE_OFF, mode_field)
        `CHK("drv_reset", 1'b0, drv_enable_r)
        `CHK("rx_reset", 1'b1, rx_output_r)
        t_modes();
        t_tx();
        t_wake();
        stop_test();
    end
endmodule // ctmw_can_mode_wake_bench

`default_nettype wire
